// ===== inc/sbr_pkg.sv
// Constants and types for the serial byte receiver
package sbr_pkg;
    // ----------------------------------------
    // Frame format
    // ----------------------------------------
    localparam int unsigned SBR_DATA_BITS = 8;
    localparam logic [3:0] SBR_BIT_CNT_LOAD = 4'h8;
    localparam int unsigned SBR_MSB_POS = 7;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned SBR_CLK_HZ = 50000000;
    localparam int unsigned SBR_CLKS_PER_INSTR = 4;
    localparam int unsigned SBR_INSTR_PER_UNIT = 4;
    localparam int unsigned SBR_OVERHEAD_INSTR = 8;
    localparam int unsigned SBR_BIT_K_DEFAULT = 206;
    localparam logic [7:0] SBR_BYTE_RESET = 8'h00;

    // ----------------------------------------
    // Receiver states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SBR_IDLE  = 2'b00,
        SBR_START = 2'b01,
        SBR_DATA  = 2'b11,
        SBR_STOP  = 2'b10
    } sbr_state_e;
endpackage : sbr_pkg

// ===== rtl/sbr_delay.sv
// Bit-time delay generator built from instruction-cycle counts
`timescale 1ns/1ns
`default_nettype none
module sbr_delay
    import sbr_pkg::*;
#(
    parameter int unsigned CW = 20
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_start,
    input  wire logic [7:0]    i_units,
    output logic               o_done
);
    // ----------------------------------------
    // Cycle counter
    // ----------------------------------------
    if (CW < 16) begin : g_bad_cw
        $error("sbr_delay: CW too small");
    end

    logic [CW-1:0] cnt_q;
    logic          busy_q;
    logic [CW-1:0] load_w;

    // Clocks = 4 clocks/instr * (4 instr per unit * units + 8 overhead)
    assign load_w = CW'((SBR_INSTR_PER_UNIT * i_units + SBR_OVERHEAD_INSTR)
                        * SBR_CLKS_PER_INSTR); // see R12 see R14

    // Count down; done pulses on the final cycle of the delay
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else if (i_start) begin
            cnt_q  <= load_w - CW'(1);
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    assign o_done = busy_q && (cnt_q == '0);
endmodule : sbr_delay
`default_nettype wire

// ===== rtl/sbr_rx.sv
// Serial byte receiver: start detect, mid-bit sampling, byte output
//
// Behaviour
// R1 - Frame: start, eight data, one stop
// R2 - Idle waits only for start level
// R3 - Recheck start half bit later, else idle
// R4 - Data sampled mid-slot from verified start
// R5 - Wait full bit, sample, shift in
// R6 - Bit counter loads 8, decrements, ends zero
// R7 - Clear byte register before first bit
// R8 - New bit enters bit 7, shifts down
// R9 - Wait one more bit to mid-stop
// R10 - Deliver byte to port, rearm
// R11 - No handshake lines used
// R12 - Bit time: 4 instr per unit plus 8
// R13 - Half bit uses constant divided by two
// R14 - Instruction cycle is four clocks
// R15 - Polarity option inverts all sampling
// R16 - Tolerate stop stretched beyond one bit
// R17 - Stop level not checked, byte delivered
// R18 - Reset enters idle, output driven
`timescale 1ns/1ns
`default_nettype none
module sbr_rx
    import sbr_pkg::*;
#(
    parameter int unsigned BIT_K = SBR_BIT_K_DEFAULT
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_rx_pin,
    input  wire logic          i_direct_line,
    output logic [7:0]         o_led_output_port,
    output logic               o_byte_valid
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // The constant is loaded into an eight-bit count, and a constant of one
    // would halve to zero and leave the start check with overhead only
    if (BIT_K < 2 || BIT_K > 255) begin : g_bad_bit_k
        $error("sbr_rx: BIT_K out of range");
    end
    if (SBR_DATA_BITS != 8) begin : g_bad_width
        $error("sbr_rx: byte path is eight bits wide");
    end

    localparam logic [7:0] BIT_UNITS  = 8'(BIT_K);
    localparam logic [7:0] HALF_UNITS = 8'(BIT_K / 2); // see R13

    // ----------------------------------------
    // Line level and state
    // ----------------------------------------
    // Through the line receiver the pin idles high and a start pulls it low;
    // the direct resistor feed skips that inversion, so every level flips.
    logic       data_lvl;
    assign data_lvl   = i_direct_line ? ~i_rx_pin : i_rx_pin; // see R15

    sbr_state_e state_q;
    logic [3:0] bits_q;
    logic [7:0] shift_q;
    logic [7:0] out_q;
    logic       valid_q;
    logic       dly_start;
    logic [7:0] dly_units;
    logic       dly_done;

    // Inverted view: start bit is a logic 0 on the data level
    logic start_lvl;
    assign start_lvl = ~data_lvl;

    // ----------------------------------------
    // Delay generator
    // ----------------------------------------
    sbr_delay #(
        .CW (20)
    ) u_delay (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_start (dly_start),
        .i_units (dly_units),
        .o_done  (dly_done)
    );

    // Launch a delay on entering start check or after a verified start or data sample point
    // Each launch but the one from idle lands on the done edge itself, so the bit grid never drifts
    always_comb begin
        dly_start = 1'b0;
        dly_units = BIT_UNITS;
        case (state_q)
            SBR_IDLE: begin
                dly_start = start_lvl;    // see R2
                dly_units = HALF_UNITS;   // see R13
            end
            SBR_START: begin
                dly_start = dly_done && start_lvl;
            end
            SBR_DATA: begin
                dly_start = dly_done;     // see R4 see R5
            end
            default: begin
                dly_start = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    // Stop level is never looked at, so a stretched stop just idles on.
    // A start level still showing after the stop sample opens a new start check.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= SBR_IDLE; // see R18
        end else begin
            case (state_q)
                SBR_IDLE: begin
                    if (start_lvl) state_q <= SBR_START; // see R2
                end
                SBR_START: begin
                    if (dly_done) begin
                        state_q <= start_lvl ? SBR_DATA : SBR_IDLE; // see R3
                    end
                end
                SBR_DATA: begin
                    if (dly_done && bits_q == 4'h1) state_q <= SBR_STOP; // see R6
                end
                SBR_STOP: begin
                    if (dly_done) state_q <= SBR_IDLE; // see R9 see R10 see R16
                end
                default: begin
                    state_q <= SBR_IDLE;
                end
            endcase
        end
    end

    // Bit counter: loaded at verified start, counted per sample
    // Four bits so that the load value of eight fits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bits_q <= 4'h0;
        end else if (state_q == SBR_START && dly_done && start_lvl) begin
            bits_q <= SBR_BIT_CNT_LOAD; // see R6
        end else if (state_q == SBR_DATA && dly_done) begin
            bits_q <= bits_q - 4'h1;    // see R6
        end
    end

    // Byte register: cleared at start, shifted in from the top
    // A rejected start leaves the register untouched
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            shift_q <= SBR_BYTE_RESET;
        end else if (state_q == SBR_START && dly_done && start_lvl) begin
            shift_q <= SBR_BYTE_RESET; // see R7
        end else if (state_q == SBR_DATA && dly_done) begin
            shift_q <= {data_lvl, shift_q[SBR_MSB_POS:1]}; // see R8 see R1
        end
    end

    // Output port holds the last byte; stop level ignored
    // No framing flag exists, so a noisy stop still hands over its byte
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_q   <= SBR_BYTE_RESET; // see R18
            valid_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (state_q == SBR_STOP && dly_done) begin
                out_q   <= shift_q; // see R10 see R17
                valid_q <= 1'b1;
            end
        end
    end

    // No handshake pins exist on this block
    assign o_led_output_port = out_q;   // see R11
    assign o_byte_valid      = valid_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Expected delay lengths in clocks, worked out apart from the counter
    localparam int BIT_CLKS  = (SBR_INSTR_PER_UNIT * BIT_K + SBR_OVERHEAD_INSTR)
                               * SBR_CLKS_PER_INSTR;
    localparam int HALF_CLKS = (SBR_INSTR_PER_UNIT * (BIT_K / 2) + SBR_OVERHEAD_INSTR)
                               * SBR_CLKS_PER_INSTR;

    // Helper: clocks since the last delay launch. The bit time is thousands
    // of clocks at the default constant, too long for a delay range, so the
    // length is checked against this count instead. Saturates while idle.
    logic [15:0] gap_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || dly_start) begin
            gap_q <= 16'h0000;
        end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    chk_half_wait: assert property (@(posedge i_clk) disable iff (i_rst) // see R13
        (state_q == SBR_IDLE && start_lvl) |=> (state_q == SBR_START)[*8])
        else $error("start check left too early");

    chk_false_start: assert property (@(posedge i_clk) disable iff (i_rst) // see R3
        (state_q == SBR_START && dly_done && !start_lvl) |=> state_q == SBR_IDLE)
        else $error("false start not rejected");

    chk_count_load: assert property (@(posedge i_clk) disable iff (i_rst) // see R6
        (state_q == SBR_START && dly_done && start_lvl) |=> bits_q == 4'h8)
        else $error("bit counter not loaded with eight");

    chk_byte_clear: assert property (@(posedge i_clk) disable iff (i_rst) // see R7
        (state_q == SBR_START && dly_done && start_lvl) |=> shift_q == 8'h00)
        else $error("byte register not cleared");

    chk_shift_top: assert property (@(posedge i_clk) disable iff (i_rst) // see R8
        (state_q == SBR_DATA && dly_done) |=>
            shift_q == {$past(data_lvl), $past(shift_q[7:1])})
        else $error("bit not shifted into top");

    chk_stop_deliver: assert property (@(posedge i_clk) disable iff (i_rst) // see R10
        (state_q == SBR_STOP && dly_done) |=>
            (o_byte_valid && o_led_output_port == $past(shift_q) && state_q == SBR_IDLE))
        else $error("byte not delivered at stop");

    chk_data_count: assert property (@(posedge i_clk) disable iff (i_rst) // see R5
        (state_q == SBR_DATA) |-> bits_q != 4'h0)
        else $error("data state with empty counter");

    chk_valid_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // see R17
        o_byte_valid |=> !o_byte_valid)
        else $error("valid longer than one cycle");

    chk_bit_timing: assert property (@(posedge i_clk) disable iff (i_rst) // see R12
        dly_done |-> gap_q == (state_q == SBR_START ? 16'(HALF_CLKS - 1)
                                                    : 16'(BIT_CLKS - 1)))
        else $error("bit delay of wrong length");

    // Idle does nothing until the start level shows
    chk_idle_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // see R2
        (state_q == SBR_IDLE && !start_lvl) |=> state_q == SBR_IDLE)
        else $error("idle left without a start level");

    // The start check is timed by the halved constant
    chk_half_units: assert property (@(posedge i_clk) disable iff (i_rst) // see R13
        (state_q == SBR_IDLE && start_lvl) |-> (dly_start && dly_units == HALF_UNITS))
        else $error("start check not timed by half constant");

    // The line is ignored between sample points
    chk_start_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see R3
        (state_q == SBR_START && !dly_done) |=> state_q == SBR_START)
        else $error("start check ended before its delay");

    // Verified start moves on to data
    chk_start_enter: assert property (@(posedge i_clk) disable iff (i_rst) // see R3
        (state_q == SBR_START && dly_done && start_lvl) |=> state_q == SBR_DATA)
        else $error("verified start not followed by data");

    // Bits are only taken at sample points
    chk_data_stay: assert property (@(posedge i_clk) disable iff (i_rst) // see R4
        (state_q == SBR_DATA && !dly_done) |=> (state_q == SBR_DATA && $stable(shift_q)))
        else $error("byte moved between sample points");

    // Every data and stop wait is one full bit
    chk_bit_units: assert property (@(posedge i_clk) disable iff (i_rst) // see R5
        (state_q == SBR_DATA && dly_done) |-> (dly_start && dly_units == BIT_UNITS))
        else $error("next bit not timed by full constant");

    // Counter walks eight down to one, then the stop wait follows
    chk_count_step: assert property (@(posedge i_clk) disable iff (i_rst) // see R6
        (state_q == SBR_DATA && dly_done) |=> bits_q == $past(bits_q) - 4'h1)
        else $error("bit counter did not step down");

    chk_stop_wait: assert property (@(posedge i_clk) disable iff (i_rst) // see R9
        (state_q == SBR_DATA && dly_done && bits_q == 4'h1) |=> state_q == SBR_STOP)
        else $error("eighth bit not followed by stop wait");

    // Port only moves together with the valid pulse
    chk_port_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see R10
        !o_byte_valid |-> $stable(o_led_output_port))
        else $error("port changed without a delivery");

    // No disable here: this one watches the reset itself
    chk_reset_idle: assert property (@(posedge i_clk) // see R18
        i_rst |=> (state_q == SBR_IDLE && !o_byte_valid
                   && o_led_output_port == SBR_BYTE_RESET))
        else $error("reset did not reach idle");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    cov_false_start: cover property (@(posedge i_clk) disable iff (i_rst)
        state_q == SBR_START && dly_done && !start_lvl);
    cov_byte_out: cover property (@(posedge i_clk) disable iff (i_rst) o_byte_valid);
    cov_direct_byte: cover property (@(posedge i_clk) disable iff (i_rst)
        o_byte_valid && i_direct_line);
    // A broken stop that still delivers, and a line idle at mark one clock after the stop sample
    cov_bad_stop: cover property (@(posedge i_clk) disable iff (i_rst)
        state_q == SBR_STOP && dly_done && start_lvl);
    cov_long_stop: cover property (@(posedge i_clk) disable iff (i_rst)
        state_q == SBR_IDLE && !start_lvl && gap_q == 16'(BIT_CLKS));
endmodule : sbr_rx
`default_nettype wire

// ===== tb/sbr_line_model.sv
// Far-side model: a host serial port sending one asynchronous frame
`timescale 1ns/1ns
`default_nettype none
module sbr_line_model #(
    parameter int unsigned T_BIT = 192
) (
    input  wire logic       i_clk,
    input  wire logic       i_send,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_direct,
    input  wire logic [1:0] i_stop,
    input  wire logic       i_glitch,
    output logic            o_line,
    output logic            o_busy
);
    logic mark_q = 1'b1; // Logical line value, idle is mark

    // Pin level follows the wiring: the line receiver shows mark as high,
    // a direct resistor feed shows it inverted
    assign o_line = i_direct ? ~mark_q : mark_q;

    // Sender; the line only moves on falling edges, away from sampling
    initial begin
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_send) begin
                @(negedge i_clk);
                o_busy = 1'b1;
                mark_q = 1'b0;
                if (i_glitch) begin
                    repeat (T_BIT / 4) @(negedge i_clk); // Noise burst, not a start
                end else begin
                    repeat (T_BIT) @(negedge i_clk);
                    for (int n = 0; n < 8; n++) begin
                        mark_q = i_byte[n];
                        repeat (T_BIT) @(negedge i_clk);
                    end
                    // Mode 0 breaks the stop bit: space for most of the slot
                    mark_q = (i_stop != 2'h0);
                    if (i_stop == 2'h0) repeat (T_BIT * 3 / 4) @(negedge i_clk);
                    mark_q = 1'b1;
                    repeat (T_BIT * i_stop) @(negedge i_clk);
                end
                mark_q = 1'b1;
                o_busy = 1'b0;
            end
        end
    end
endmodule : sbr_line_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the serial byte receiver
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sbr_pkg::*;
    localparam int unsigned K = 10;
    localparam int unsigned T_HALF = (SBR_INSTR_PER_UNIT * (K / 2) + SBR_OVERHEAD_INSTR) * 4;
    localparam int unsigned T_BIT = (SBR_INSTR_PER_UNIT * K + SBR_OVERHEAD_INSTR) * 4;
    localparam int unsigned T_DONE = T_HALF + 9 * T_BIT;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       send = 1'b0, direct = 1'b0, glitch = 1'b0;
    logic [7:0] byte_in = 8'h00;
    logic [1:0] stop = 2'h1;
    logic       line, busy, valid;
    logic [7:0] port;
    int         n_fail = 0;
    int         check_count = 0;

    always #10 i_clk = ~i_clk;

    sbr_rx #(.BIT_K(K)) sbr_rx_i (.i_clk(i_clk), .i_rst(i_rst), .i_rx_pin(line),
        .i_direct_line(direct), .o_led_output_port(port), .o_byte_valid(valid));
    sbr_line_model #(.T_BIT(T_BIT)) sbr_line_model_i (.i_clk(i_clk), .i_send(send),
        .i_byte(byte_in), .i_direct(direct), .i_stop(stop), .i_glitch(glitch),
        .o_line(line), .o_busy(busy));

    // ----------------------------------------
    // Shared checking and framing
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // One frame; time is counted from the edge that first sees the start level
    task automatic rx_frame(input logic [7:0] b, input logic d, input logic [1:0] s,
                            input logic g, input logic want);
        int         t;
        logic [7:0] old;
        t = -1;
        old = port;
        @(negedge i_clk);
        {byte_in, direct, stop, glitch, send} = {b, d, s, g, 1'b1};
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        send = 1'b0;
        for (int c = 1; c <= T_DONE + 2 * T_BIT && t < 0; c++) begin
            @(posedge i_clk);
            #1;
            if (valid === 1'b1) t = c;
            if (valid === 1'b1) check("byte", port, want ? b : old);
        end
        if (want) begin
            check("time", {7'h0, t >= T_DONE && t <= T_DONE + 16}, 8'h1);
            if (t < 0) give_verdict();
            @(posedge i_clk);
            #1;
            check("pulse", {7'h0, valid}, 8'h0);
        end else begin
            check("refused", {7'h0, t < 0}, 8'h1);
            check("held", port, old);
        end
        for (int c = 0; c < 4 * T_BIT && busy !== 1'b0; c++) @(posedge i_clk);
        if (busy !== 1'b0) begin
            n_fail++;
            give_verdict();
        end
    endtask : rx_frame

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        repeat (2) @(posedge i_clk);
        #1;
        check("reset port", port, SBR_BYTE_RESET);
        check("reset valid", {7'h0, valid}, 8'h0);
        @(negedge i_clk);
        i_rst = 1'b0;
        $display("test reset done");
    endtask : test_reset

    // Back-to-back frames with one stop bit, both polarities, edge patterns
    task automatic test_patterns();
        logic [7:0] tbl [6] = '{8'h5a, 8'h01, 8'h80, 8'ha5, 8'hff, 8'h00};
        foreach (tbl[i]) rx_frame(tbl[i], i[0], 2'h1, 1'b0, 1'b1);
        $display("test patterns done");
    endtask : test_patterns

    task automatic test_stretched();
        rx_frame(8'h3c, 1'b1, 2'h2, 1'b0, 1'b1);
        rx_frame(8'hc3, 1'b0, 2'h2, 1'b0, 1'b1);
        $display("test stretched done");
    endtask : test_stretched

    // Short start pulses must leave the port alone in either polarity
    task automatic test_glitch();
        rx_frame(8'h00, 1'b0, 2'h1, 1'b1, 1'b0);
        rx_frame(8'h00, 1'b1, 2'h1, 1'b1, 1'b0);
        $display("test glitch done");
    endtask : test_glitch

    // Broken stop bit still delivers; the tail of the space is not a new frame
    task automatic test_bad_stop();
        rx_frame(8'h96, 1'b1, 2'h0, 1'b0, 1'b1);
        rx_frame(8'h00, 1'b1, 2'h0, 1'b1, 1'b0);
        rx_frame(8'h69, 1'b0, 2'h1, 1'b0, 1'b1);
        $display("test bad stop done");
    endtask : test_bad_stop

    initial begin
        test_reset();
        test_patterns();
        test_stretched();
        test_glitch();
        test_bad_stop();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
